// ---- dbsu_core_model.sv ----
// core-side model: decode, data-access and retire pulses
`timescale 1ns/1ns
module dbsu_core_model (
  input  wire logic        clk_i,
  output logic             dec_v_o,
  output logic [23:0]      dec_a_o,
  output logic [7:0]       op_o,
  output logic             dv_o,
  output logic             dw_o,
  output logic [23:0]      da_o,
  output logic [7:0]       db_o,
  output logic             end_o
);
  initial begin
    {dec_v_o, dv_o, dw_o, end_o, dec_a_o, op_o, da_o, db_o} = '0;
  end
  // fields go to their inverse once released so stale values never match
  task automatic fetch(input logic [23:0] a, input logic [7:0] op);
    {dec_v_o, dec_a_o, op_o} <= {1'b1, a, op};
    @(posedge clk_i);
    {dec_v_o, dec_a_o, op_o} <= {1'b0, ~a, ~op};
  endtask
  task automatic access(input logic w, input logic [23:0] a,
                        input logic [7:0] b);
    {dv_o, dw_o, da_o, db_o} <= {1'b1, w, a, b};
    @(posedge clk_i);
    {dv_o, dw_o, da_o, db_o} <= {1'b0, ~w, ~a, ~b};
  endtask
  task automatic retire();
    end_o <= 1'b1;
    @(posedge clk_i);
    end_o <= 1'b0;
  endtask
endmodule

// ---- dbsu_match.sv ----
// breakpoint comparator: decodes the condition code against bus activity
`timescale 1ns/1ns
module dbsu_match
  import dbsu_pkg::*;
(
  dbsu_match_if.matcher m
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic outside(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] lo,
                                   input logic [ADDR_W-1:0] hi);
    outside = (a <= lo) || (a >= hi);
  endfunction

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  always_comb begin
    logic any_en;
    logic dok;
    logic fsel;
    logic dsel;
    logic deq1;
    logic deq2;
    logic feq1;
    logic feq2;
    any_en = m.rd_en | m.wr_en;
    dok    = m.data_valid & (m.data_write ? m.wr_en : m.rd_en);
    fsel   = m.fetch_valid & ~any_en;
    dsel   = dok & any_en;
    deq1   = m.data_addr == m.bk1;
    deq2   = m.data_addr == m.bk2;
    feq1   = m.fetch_addr == m.bk1;
    feq2   = m.fetch_addr == m.bk2;
    m.fetch_hit1 = 1'b0;
    m.fetch_hit2 = 1'b0;
    m.data_hit1  = 1'b0;
    m.data_hit2  = 1'b0;
    unique case (m.code)
      BC_VALUE: begin
        m.data_hit1 = dsel & deq1 & (m.data_byte == m.bk2[7:0]);
      end
      BC_RANGE: begin
        m.fetch_hit1 = fsel & in_range(m.fetch_addr, m.bk1, m.bk2);
        m.data_hit1  = dsel & in_range(m.data_addr, m.bk1, m.bk2);
      end
      BC_OUTSIDE: begin
        m.fetch_hit1 = fsel & outside(m.fetch_addr, m.bk1, m.bk2);
        m.data_hit1  = dsel & outside(m.data_addr, m.bk1, m.bk2);
      end
      BC_PAIR: begin
        m.fetch_hit1 = fsel & feq1;
        m.fetch_hit2 = fsel & feq2;
        m.data_hit1  = dsel & deq1;
        m.data_hit2  = dsel & deq2;
      end
      BC_FETCH1: begin
        m.fetch_hit1 = m.fetch_valid & feq1;
        m.fetch_hit2 = fsel & feq2;
        m.data_hit2  = dsel & deq2;
      end
      BC_STACK: begin
        m.data_hit1  = m.data_valid & m.data_write & m.data_stack &
                       (m.data_addr <= m.bk1);
        m.fetch_hit2 = fsel & feq2;
        m.data_hit2  = dsel & deq2;
      end
      BC_OFF_A, BC_OFF_B: begin
        m.data_hit1 = 1'b0;
      end
    endcase
  end

endmodule

// ---- dbsu_match_if.sv ----
// configuration and hit lines between the unit and its comparator
`timescale 1ns/1ns
interface dbsu_match_if;
  import dbsu_pkg::*;
  logic [ADDR_W-1:0] bk1;
  logic [ADDR_W-1:0] bk2;
  logic [2:0]        code;
  logic              rd_en;
  logic              wr_en;
  logic              fetch_valid;
  logic [ADDR_W-1:0] fetch_addr;
  logic              data_valid;
  logic              data_write;
  logic              data_stack;
  logic [ADDR_W-1:0] data_addr;
  logic [7:0]        data_byte;
  logic              fetch_hit1;
  logic              fetch_hit2;
  logic              data_hit1;
  logic              data_hit2;

  modport ctrl (output bk1, bk2, code, rd_en, wr_en, fetch_valid,
                fetch_addr, data_valid, data_write, data_stack, data_addr,
                data_byte,
                input  fetch_hit1, fetch_hit2, data_hit1, data_hit2);
  modport matcher (input bk1, bk2, code, rd_en, wr_en, fetch_valid,
                   fetch_addr, data_valid, data_write, data_stack,
                   data_addr, data_byte,
                   output fetch_hit1, fetch_hit2, data_hit1, data_hit2);
endinterface

// ---- dbsu_pkg.sv ----
// constants of the debug breakpoint and stall unit
package dbsu_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [15:0] BK1E_IDX   = 16'h7F90;
  localparam logic [15:0] BK1H_IDX   = 16'h7F91;
  localparam logic [15:0] BK1L_IDX   = 16'h7F92;
  localparam logic [15:0] BK2E_IDX   = 16'h7F93;
  localparam logic [15:0] BK2H_IDX   = 16'h7F94;
  localparam logic [15:0] BREAKPOINT_TWO_LOW_BYTE_IDX   = 16'h7F95;
  localparam logic [15:0] CTRL1_IDX  = 16'h7F96;
  localparam logic [15:0] CTRL2_IDX  = 16'h7F97;
  localparam logic [15:0] FLAG_IDX   = 16'h7F98;
  localparam logic [15:0] STALLC_IDX = 16'h7F99;

  // ----------------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------------
  localparam int          ADDR_W     = 24;
  localparam logic [7:0]  BK_RST     = 8'hFF;
  localparam logic [7:0]  CTRL_RST   = 8'h00;

  // ----------------------------------------------------------------------
  // debug_control_one fields
  // ----------------------------------------------------------------------
  localparam int          WATCHDOG_FREEZE_ON_STALL_BIT = 7;
  localparam int          CODE_HI    = 5;
  localparam int          CODE_LO    = 3;
  localparam int          BIR_BIT    = 2;
  localparam int          BIW_BIT    = 1;
  localparam logic [7:0]  CTRL1_MASK = 8'hBE;

  // ----------------------------------------------------------------------
  // debug_flag_status and debug_stall_control fields
  // ----------------------------------------------------------------------
  localparam int          DIR_BIT    = 0;
  localparam int          MF1_BIT    = 1;
  localparam int          MF2_BIT    = 2;
  localparam int          SWF_BIT    = 3;
  localparam int          STEPF_BIT  = 4;
  localparam logic [7:0]  FLAG_MASK  = 8'h1F;
  localparam int          STALL_BIT  = 0;
  localparam int          FLUSH_BIT  = 1;
  localparam int          SOFT_BREAK_ENABLE_BIT = 2;
  localparam int          STEP_BIT   = 3;
  localparam logic [7:0]  STALLC_MASK = 8'h0D;

  // ----------------------------------------------------------------------
  // breakpoint_condition_code values and opcodes
  // ----------------------------------------------------------------------
  localparam logic [2:0]  BC_VALUE   = 3'h0;
  localparam logic [2:0]  BC_RANGE   = 3'h1;
  localparam logic [2:0]  BC_OUTSIDE = 3'h2;
  localparam logic [2:0]  BC_OFF_A   = 3'h3;
  localparam logic [2:0]  BC_PAIR    = 3'h4;
  localparam logic [2:0]  BC_FETCH1  = 3'h5;
  localparam logic [2:0]  BC_OFF_B   = 3'h6;
  localparam logic [2:0]  BC_STACK   = 3'h7;
  localparam logic [7:0]  SOFT_BREAK_OPCODE = 8'h8B;

endpackage

// ---- dbsu_top.sv ----
// debug breakpoint and stall unit: registers, break logic, stall control
`timescale 1ns/1ns

module dbsu_top
  import dbsu_pkg::*;
(
  input  wire logic              CLOCK_I,
  input  wire logic              RST_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [31:0]       PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  input  wire logic              LINK_ACTIVE_I,
  input  wire logic              LINK_DEBUG_ENABLE_I,
  input  wire logic              DECODE_VALID_I,
  input  wire logic [ADDR_W-1:0] DECODE_ADDR_I,
  input  wire logic [7:0]        DECODE_OPCODE_I,
  input  wire logic              DATA_VALID_I,
  input  wire logic              DATA_WRITE_I,
  input  wire logic              DATA_STACK_I,
  input  wire logic [ADDR_W-1:0] DATA_ADDR_I,
  input  wire logic [7:0]        DATA_BYTE_I,
  input  wire logic              INSTR_END_I,
  input  wire logic              WINDOW_WATCHDOG_HW_OPT_I,
  input  wire logic              INDEPENDENT_WATCHDOG_HW_OPT_I,
  output logic                   STALL_O,
  output logic                   FLUSH_O,
  output logic                   WINDOW_WATCHDOG_FREEZE_O,
  output logic                   INDEPENDENT_WATCHDOG_FREEZE_O
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic hit_idx(input logic [31:0] a,
                                   input logic [15:0] idx);
    hit_idx = a == 32'({idx, 2'b00});
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] wr_v,
                                       input logic       we);
    merge = we ? wr_v : old_v;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0] bk1_reg,    bk1_next;
  logic [ADDR_W-1:0] bk2_reg,    bk2_next;
  logic [7:0]        ctrl1_reg,  ctrl1_next;
  logic [7:0]        ctrl2_reg,  ctrl2_next;
  logic [7:0]        flag_reg,   flag_next;
  logic [7:0]        stallc_reg, stallc_next;
  logic              pend_reg,   pend_next;
  logic              armed_reg,  armed_next;
  logic              boot_reg,   boot_next;
  logic              flush_reg,  flush_next;
  logic [31:0]       rdata_reg,  rdata_next;

  logic              link_ok;
  logic              wr_acc;
  logic              mapped;
  logic [7:0]        wbyte;
  logic              seq_mode;
  logic              soft_hit;
  logic              step_hit;
  logic              fh1;
  logic              fh2;
  logic              instr_hit;
  logic              boot_hit;
  logic              data_hit;
  logic              stall_set;
  logic              stall_wr;
  logic              freeze;

  dbsu_match_if mif ();

  dbsu_match u_match (
    .m (mif.matcher)
  );

  // ----------------------------------------------------------------------
  // comparator hookup
  // ----------------------------------------------------------------------
  assign mif.bk1         = bk1_reg;
  assign mif.bk2         = bk2_reg;
  assign mif.code        = ctrl1_reg[CODE_HI:CODE_LO];
  assign mif.rd_en       = ctrl1_reg[BIR_BIT];
  assign mif.wr_en       = ctrl1_reg[BIW_BIT];
  assign mif.fetch_valid = DECODE_VALID_I;
  assign mif.fetch_addr  = DECODE_ADDR_I;
  assign mif.data_valid  = DATA_VALID_I;
  assign mif.data_write  = DATA_WRITE_I;
  assign mif.data_stack  = DATA_STACK_I;
  assign mif.data_addr   = DATA_ADDR_I;
  assign mif.data_byte   = DATA_BYTE_I;

  // ----------------------------------------------------------------------
  // break and stall decisions
  // ----------------------------------------------------------------------
  // the link must be up and its debug enable set before any break or stall fires; the flush pulse is not gated
  assign link_ok   = LINK_ACTIVE_I & LINK_DEBUG_ENABLE_I;
  assign seq_mode  = (mif.code == BC_PAIR) & ~mif.rd_en & ~mif.wr_en;
  assign fh1       = mif.fetch_hit1 & ~seq_mode;
  assign fh2       = mif.fetch_hit2 & (~seq_mode | armed_reg);
  assign soft_hit  = DECODE_VALID_I & stallc_reg[SOFT_BREAK_ENABLE_BIT] &
                     (DECODE_OPCODE_I == SOFT_BREAK_OPCODE);
  assign step_hit  = DECODE_VALID_I & stallc_reg[STEP_BIT];
  assign instr_hit = link_ok & (fh1 | fh2 | soft_hit | step_hit);
  // one-shot data-read break at breakpoint one left armed by reset
  assign boot_hit  = boot_reg & DATA_VALID_I & ~DATA_WRITE_I &
                     (DATA_ADDR_I == bk1_reg);
  assign data_hit  = link_ok & (mif.data_hit1 | mif.data_hit2 | boot_hit);
  // data breaks wait for the end of the executing instruction
  assign stall_set = instr_hit |
                     (link_ok & (pend_reg | data_hit) & INSTR_END_I);
  assign STALL_O   = link_ok & (stallc_reg[STALL_BIT] | instr_hit);
  assign freeze    = ctrl1_reg[WATCHDOG_FREEZE_ON_STALL_BIT] & STALL_O;
  assign WINDOW_WATCHDOG_FREEZE_O = freeze & ~WINDOW_WATCHDOG_HW_OPT_I;
  assign INDEPENDENT_WATCHDOG_FREEZE_O = freeze & ~INDEPENDENT_WATCHDOG_HW_OPT_I;
  assign FLUSH_O   = flush_reg;

  // ----------------------------------------------------------------------
  // register port: zero wait states, read data staged in setup
  // ----------------------------------------------------------------------
  // this port is the debug link's on-the-fly access path, not the core bus
  assign wr_acc  = PSEL_I & PENABLE_I & PWRITE_I & mapped;
  assign wbyte   = PWDATA_I[7:0];
  assign mapped  = hit_idx(PADDR_I, BK1E_IDX) | hit_idx(PADDR_I, BK1H_IDX) |
                   hit_idx(PADDR_I, BK1L_IDX) | hit_idx(PADDR_I, BK2E_IDX) |
                   hit_idx(PADDR_I, BK2H_IDX) | hit_idx(PADDR_I, BREAKPOINT_TWO_LOW_BYTE_IDX) |
                   hit_idx(PADDR_I, CTRL1_IDX) |
                   hit_idx(PADDR_I, CTRL2_IDX) |
                   hit_idx(PADDR_I, FLAG_IDX) | hit_idx(PADDR_I, STALLC_IDX);
  assign stall_wr  = wr_acc & hit_idx(PADDR_I, STALLC_IDX);
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
  assign PRDATA_O  = rdata_reg;

  always_comb begin
    logic [7:0] rb;
    rb = 8'h00;
    if (hit_idx(PADDR_I, BK1E_IDX)) begin
      rb = bk1_reg[23:16];
    end else if (hit_idx(PADDR_I, BK1H_IDX)) begin
      rb = bk1_reg[15:8];
    end else if (hit_idx(PADDR_I, BK1L_IDX)) begin
      rb = bk1_reg[7:0];
    end else if (hit_idx(PADDR_I, BK2E_IDX)) begin
      rb = bk2_reg[23:16];
    end else if (hit_idx(PADDR_I, BK2H_IDX)) begin
      rb = bk2_reg[15:8];
    end else if (hit_idx(PADDR_I, BREAKPOINT_TWO_LOW_BYTE_IDX)) begin
      rb = bk2_reg[7:0];
    end else if (hit_idx(PADDR_I, CTRL1_IDX)) begin
      rb = ctrl1_reg;
    end else if (hit_idx(PADDR_I, CTRL2_IDX)) begin
      rb = ctrl2_reg;
    end else if (hit_idx(PADDR_I, FLAG_IDX)) begin
      rb = flag_reg;
    end else if (hit_idx(PADDR_I, STALLC_IDX)) begin
      rb = stallc_reg;
    end
    rdata_next = rdata_reg;
    if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
      rdata_next = 32'(rb);
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    bk1_next[23:16] = merge(bk1_reg[23:16], wbyte,
                            wr_acc & hit_idx(PADDR_I, BK1E_IDX));
    bk1_next[15:8]  = merge(bk1_reg[15:8], wbyte,
                            wr_acc & hit_idx(PADDR_I, BK1H_IDX));
    bk1_next[7:0]   = merge(bk1_reg[7:0], wbyte,
                            wr_acc & hit_idx(PADDR_I, BK1L_IDX));
    bk2_next[23:16] = merge(bk2_reg[23:16], wbyte,
                            wr_acc & hit_idx(PADDR_I, BK2E_IDX));
    bk2_next[15:8]  = merge(bk2_reg[15:8], wbyte,
                            wr_acc & hit_idx(PADDR_I, BK2H_IDX));
    bk2_next[7:0]   = merge(bk2_reg[7:0], wbyte,
                            wr_acc & hit_idx(PADDR_I, BREAKPOINT_TWO_LOW_BYTE_IDX));
    ctrl1_next = merge(ctrl1_reg, wbyte & CTRL1_MASK,
                       wr_acc & hit_idx(PADDR_I, CTRL1_IDX));
    ctrl2_next = merge(ctrl2_reg, wbyte,
                       wr_acc & hit_idx(PADDR_I, CTRL2_IDX));
    boot_next  = boot_reg & ~boot_hit & ~link_ok;
    if (wr_acc & hit_idx(PADDR_I, CTRL1_IDX)) begin
      boot_next = 1'b0;
    end
    if (boot_reg & ~link_ok) begin
      boot_next = 1'b1;
    end
    if (boot_reg & link_ok & ~boot_hit &
        ~(wr_acc & hit_idx(PADDR_I, CTRL1_IDX))) begin
      boot_next = 1'b1;
    end
    // hardware sets win over a host write in the same cycle
    flag_next = merge(flag_reg, wbyte & FLAG_MASK,
                      wr_acc & hit_idx(PADDR_I, FLAG_IDX));
    if (instr_hit) begin
      flag_next[MF1_BIT]   = flag_next[MF1_BIT] | fh1;
      flag_next[MF2_BIT]   = flag_next[MF2_BIT] | fh2;
      flag_next[SWF_BIT]   = flag_next[SWF_BIT] | soft_hit;
      flag_next[STEPF_BIT] = flag_next[STEPF_BIT] | step_hit;
    end
    if (data_hit) begin
      flag_next[MF1_BIT] = flag_next[MF1_BIT] | mif.data_hit1 | boot_hit;
      flag_next[MF2_BIT] = flag_next[MF2_BIT] | mif.data_hit2;
      flag_next[DIR_BIT] = ~DATA_WRITE_I;
    end
    stallc_next = merge(stallc_reg, wbyte & STALLC_MASK, stall_wr);
    stallc_next[STALL_BIT] = stallc_next[STALL_BIT] | stall_set;
    flush_next = stall_wr & wbyte[FLUSH_BIT];
    pend_next  = link_ok & (pend_reg | data_hit) & ~INSTR_END_I;
    armed_next = armed_reg;
    if (~seq_mode | (link_ok & fh2)) begin
      armed_next = 1'b0;
    end else if (link_ok & mif.fetch_hit1) begin
      armed_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      bk1_reg    <= {BK_RST, BK_RST, BK_RST};
      bk2_reg    <= {BK_RST, BK_RST, BK_RST};
      ctrl1_reg  <= CTRL_RST;
      ctrl2_reg  <= CTRL_RST;
      flag_reg   <= CTRL_RST;
      stallc_reg <= CTRL_RST;
      pend_reg   <= 1'b0;
      armed_reg  <= 1'b0;
      boot_reg   <= 1'b1;
      flush_reg  <= 1'b0;
      rdata_reg  <= 32'h00000000;
    end else begin
      bk1_reg    <= bk1_next;
      bk2_reg    <= bk2_next;
      ctrl1_reg  <= ctrl1_next;
      ctrl2_reg  <= ctrl2_next;
      flag_reg   <= flag_next;
      stallc_reg <= stallc_next;
      pend_reg   <= pend_next;
      armed_reg  <= armed_next;
      boot_reg   <= boot_next;
      flush_reg  <= flush_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  a_idle_no_stall: assert property (!link_ok |-> !STALL_O)
    else $error("stall raised while debug link inactive");
  a_abort_stall: assert property (
    (link_ok && stall_wr && wbyte[STALL_BIT]) ##1 link_ok |-> STALL_O)
    else $error("abort write did not stall the core");
  a_stall_holds: assert property (
    (link_ok && stallc_reg[STALL_BIT] && !stall_wr) ##1 link_ok
      |-> STALL_O)
    else $error("stall dropped without a host clear");
  a_soft_break: assert property (
    (link_ok && soft_hit) |-> STALL_O ##1
      (flag_reg[SWF_BIT] && stallc_reg[STALL_BIT]))
    else $error("soft break did not stall and flag");
  a_data_defer: assert property (
    (link_ok && pend_reg && INSTR_END_I)
      |=> stallc_reg[STALL_BIT] && !pend_reg)
    else $error("data break not stalled at instruction end");
  a_codes_off: assert property (
    (mif.code == BC_OFF_A || mif.code == BC_OFF_B) |->
      !(mif.data_hit1 || mif.data_hit2 ||
        mif.fetch_hit1 || mif.fetch_hit2))
    else $error("disabled code produced a hit");
  a_step_stall: assert property (
    (link_ok && step_hit) |-> STALL_O ##1 flag_reg[STEPF_BIT])
    else $error("step did not stall in decode");
  a_dog_freeze: assert property (
    WINDOW_WATCHDOG_FREEZE_O |-> (STALL_O && ctrl1_reg[WATCHDOG_FREEZE_ON_STALL_BIT] &&
                       !WINDOW_WATCHDOG_HW_OPT_I))
    else $error("window watchdog frozen wrongly");
  a_dir_flag: assert property (
    (data_hit && !DATA_WRITE_I) |=> flag_reg[DIR_BIT])
    else $error("read break left direction flag low");
  a_pair_flag: assert property (
    (instr_hit && seq_mode && fh2) |=> flag_reg[MF2_BIT])
    else $error("sequenced fetch break did not flag two");
  a_flush_pulse: assert property (
    (stall_wr && wbyte[FLUSH_BIT]) |=> FLUSH_O)
    else $error("flush write gave no flush pulse");

  c_abort: cover property (stall_wr && wbyte[STALL_BIT] && link_ok);
  c_data_break: cover property (pend_reg ##1 stallc_reg[STALL_BIT]);
  c_soft_break: cover property (link_ok && soft_hit);
  c_pair_break: cover property (armed_reg ##[1:20] (instr_hit && fh2));

endmodule

// ---- dbsu_top_tb.sv ----
// self-checking bench of the debug breakpoint and stall unit
`timescale 1ns/1ns
module dbsu_top_tb import dbsu_pkg::*; ;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rdat;
  logic        pready, pslverr, serr, act = 1'b0, den = 1'b0, iwhw = 1'b0;
  logic        stall, flush, wwfz, iwfz, dv, dw, dec_v, iend;
  logic [23:0] dec_a, da;
  logic [7:0]  op, db;
  int          fail_count = 0, num_checks = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  dbsu_core_model i_core (.clk_i(clk), .dec_v_o(dec_v), .dec_a_o(dec_a),
    .op_o(op), .dv_o(dv), .dw_o(dw), .da_o(da), .db_o(db), .end_o(iend));
  dbsu_top i_dut (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LINK_ACTIVE_I(act), .LINK_DEBUG_ENABLE_I(den), .DECODE_VALID_I(dec_v),
    .DECODE_ADDR_I(dec_a), .DECODE_OPCODE_I(op), .DATA_VALID_I(dv),
    .DATA_WRITE_I(dw), .DATA_STACK_I(1'b0), .DATA_ADDR_I(da),
    .DATA_BYTE_I(db), .INSTR_END_I(iend), .WINDOW_WATCHDOG_HW_OPT_I(1'b0),
    .INDEPENDENT_WATCHDOG_HW_OPT_I(iwhw), .STALL_O(stall), .FLUSH_O(flush),
    .WINDOW_WATCHDOG_FREEZE_O(wwfz), .INDEPENDENT_WATCHDOG_FREEZE_O(iwfz));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cs(input string nm, input logic e);
    #1 chk(nm, {31'h0, e}, {31'h0, stall});
    @(posedge clk);
  endtask
  // --------------------------------------------------------------------
  // bus master: the unit answers without wait states, but the wait is kept
  // --------------------------------------------------------------------
  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
    int n = 0;
    {psel, pwr, paddr, pwdata} <= {1'b1, w, 14'h0, i, 2'h0, 24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    {rdat, serr} = {prdata, pslverr};
    {psel, pen} <= 2'b00;
    if (n >= 20) begin
      chk("pready", 32'h1, 32'h0);
      report_and_stop();
    end
    @(posedge clk);
  endtask
  task automatic rc(input string nm, input logic [15:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk(nm, {24'h0, e}, rdat);
  endtask
  task automatic s_regs();
    rc("bk1_ext", BK1E_IDX, BK_RST);
    rc("bk2_low", BREAKPOINT_TWO_LOW_BYTE_IDX, BK_RST);
    rc("ctrl1", CTRL1_IDX, CTRL_RST);
    apb(1'b0, 16'h7FA0, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, serr});
  endtask
  task automatic s_arm();
    {act, den} <= 2'b11;
    i_core.access(1'b0, 24'hFFFFFF, 8'hFF);
    cs("stall_before_end", 1'b0);
    i_core.retire();
    cs("reset_arm", 1'b1);
    apb(1'b1, STALLC_IDX, 8'h00);
    cs("arm_resume", 1'b0);
  endtask
  task automatic s_value();
    logic [2:0] offs [2] = '{BC_OFF_A, BC_OFF_B};
    apb(1'b1, BK1E_IDX, 8'h00);
    apb(1'b1, BK1H_IDX, 8'h12);
    apb(1'b1, BK1L_IDX, 8'h34);
    apb(1'b1, BREAKPOINT_TWO_LOW_BYTE_IDX, 8'h5A);
    apb(1'b1, CTRL1_IDX, {2'b00, BC_VALUE, 3'b010});
    i_core.access(1'b1, 24'h001234, 8'h5B);
    i_core.retire();
    cs("byte_mismatch", 1'b0);
    i_core.access(1'b1, 24'h001234, 8'h5A);
    i_core.retire();
    cs("value_break", 1'b1);
    rc("value_flags", FLAG_IDX, 8'h02);
    apb(1'b1, FLAG_IDX, 8'h00);
    apb(1'b1, STALLC_IDX, 8'h00);
    foreach (offs[k]) begin
      apb(1'b1, CTRL1_IDX, {2'b00, offs[k], 3'b110});
      i_core.access(1'b1, 24'h001234, 8'h5A);
      i_core.retire();
      cs("off_code", 1'b0);
      rc("off_flags", FLAG_IDX, 8'h00);
    end
  endtask
  task automatic s_abort();
    apb(1'b1, STALLC_IDX, 8'h01);
    cs("abort", 1'b1);
    apb(1'b1, CTRL1_IDX, 8'h80);
    iwhw <= 1'b1;
    #1 chk("freeze", 32'h2, {30'h0, wwfz, iwfz});
    @(posedge clk);
    act <= 1'b0;
    cs("link_off", 1'b0);
    act <= 1'b1;
    apb(1'b1, STALLC_IDX, 8'h00);
    cs("abort_resume", 1'b0);
  endtask
  task automatic s_soft();
    apb(1'b1, STALLC_IDX, 8'h04);
    i_core.fetch(24'h000200, SOFT_BREAK_OPCODE);
    cs("soft_stall", 1'b1);
    rc("soft_ctl", STALLC_IDX, 8'h05);
    rc("soft_flag", FLAG_IDX, 8'h08);
    apb(1'b1, STALLC_IDX, 8'h06);
    cs("soft_resume", 1'b0);
  endtask
  task automatic s_codes();
    apb(1'b1, FLAG_IDX, 8'h00);
    apb(1'b1, STALLC_IDX, 8'h00);
    apb(1'b1, CTRL1_IDX, {2'b00, BC_RANGE, 3'b000});
    i_core.fetch(24'h000100, 8'h00);
    cs("range_out", 1'b0);
    i_core.fetch(24'h002000, 8'h00);
    cs("range_fetch", 1'b1);
    rc("range_flags", FLAG_IDX, 8'h02);
    apb(1'b1, FLAG_IDX, 8'h00);
    apb(1'b1, STALLC_IDX, 8'h00);
    apb(1'b1, CTRL1_IDX, {2'b00, BC_PAIR, 3'b000});
    i_core.fetch(24'hFFFF5A, 8'h00);
    cs("pair_early", 1'b0);
    i_core.fetch(24'h001234, 8'h00);
    cs("pair_arm", 1'b0);
    i_core.fetch(24'hFFFF5A, 8'h00);
    cs("pair_break", 1'b1);
    rc("pair_flags", FLAG_IDX, 8'h04);
    apb(1'b1, STALLC_IDX, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_regs();
    s_arm();
    s_value();
    s_abort();
    s_soft();
    s_codes();
    report_and_stop();
  end
endmodule
